// [core/crs_pkg.sv]
// constants and types shared by the call and return instruction block
package crs_pkg;
   localparam int PC_W = 21;
   localparam int STK_DEPTH = 31;
   localparam int STK_PTR_W = 5;
   localparam logic [3:0] OP_RELCALL_TOP = 4'hD;
   localparam int RELCALL_SEL_BIT = 11;
   localparam int OFS_W = 11;
   localparam logic [15:0] OP_SWRESET = 16'h00FF;
   localparam logic [14:0] OP_IRET_TOP = 15'h0008;
   localparam logic [7:0] OP_RETLIT_TOP = 8'h0C;
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [STK_PTR_W-1:0] PTR_RST = 5'h00;
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q4 = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   typedef enum logic [1:0] {CRS_EXEC, CRS_FLUSH} crs_state_t;
endpackage

// [core/crs_stack_if.sv]
// port bundle between the control block and its return stack memory
`timescale 1ns/10ps
`default_nettype none
interface crs_stack_if;
   import crs_pkg::*;
   logic                 push;
   logic                 pop;
   logic [PC_W-1:0]      push_data;
   logic [PC_W-1:0]      top_data;
   modport ctrl (output push, output pop, output push_data, input top_data);
   modport mem  (input push, input pop, input push_data, output top_data);
endinterface
`default_nettype wire

// [core/crs_stack_mem.sv]
// return stack memory with registered top value
`timescale 1ns/10ps
`default_nettype none
module crs_stack_mem
   import crs_pkg::*;
(
   input  wire logic    clock_in,
   input  wire logic    rst_n_in,
   crs_stack_if.mem     stk
);
   logic [PC_W-1:0]      mem_ff [STK_DEPTH];
   logic [STK_PTR_W-1:0] ptr_ff;
   logic [STK_PTR_W-1:0] nxt_ptr;
   logic [PC_W-1:0]      top_ff;
   logic [PC_W-1:0]      nxt_top;

   always_comb
   begin
      nxt_ptr = ptr_ff;
      nxt_top = top_ff;
      if (stk.push)
      begin
         nxt_ptr = ptr_ff + 5'h01;
         nxt_top = stk.push_data;
      end
      else if (stk.pop)
      begin
         nxt_ptr = ptr_ff - 5'h01;
         // underflow reads the reset value instead of stale data
         nxt_top = (ptr_ff > 5'h01) ? mem_ff[ptr_ff - 5'h02] : PC_RST;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ptr_ff <= PTR_RST;
         top_ff <= PC_RST;
      end
      else
      begin
         ptr_ff <= nxt_ptr;
         top_ff <= nxt_top;
      end
   end

   // storage has no reset; pointer guards it
   always_ff @(posedge clock_in)
   begin
      if (stk.push && ptr_ff < STK_PTR_W'(STK_DEPTH))
         mem_ff[ptr_ff] <= stk.push_data;
   end

   assign stk.top_data = top_ff;
endmodule
`default_nettype wire

// [core/crs_core.sv]
// decode and execute of relative call, software reset and the two returns
// Summary of operation
// - relative call is 1101_1 plus signed offset
// - call pushes next instruction address first
// - call loads incremented pc plus twice offset
// - call takes two cycles, second is idle
// - opcode 00FF resets all master-clear registers
// - software reset is one cycle, starts Q2
// - interrupt return pops stack into pc
// - interrupt return sets high or low enable
// - shadow bit restores working, flags, bank
// - return with literal loads literal into working
// - literal return pops pc with working write
// - stack returns leave pc latches unchanged
`timescale 1ns/10ps
`default_nettype none
module crs_core
   import crs_pkg::*;
(
   input  wire logic                      clock_in,
   input  wire logic                      nrst_in,
   input  wire logic [1:0]                q_phase_in,
   input  wire logic                      instr_valid_in,
   input  wire logic [15:0]               instr_in,
   input  wire logic [PC_W-1:0]           pc_in,
   input  wire logic                      irq_high_level_in,
   input  wire logic [7:0]                working_shadow_in,
   input  wire logic [7:0]                flags_shadow_in,
   input  wire logic [3:0]                bank_select_shadow_in,
   input  wire logic [7:0]                pc_high_latch_wr_in,
   input  wire logic                      pc_high_latch_we_in,
   output logic [PC_W-1:0]                pc_out,
   output logic                           pc_load_out,
   output logic [PC_W-1:0]                stack_top_value_out,
   output logic [7:0]                     working_out,
   output logic [7:0]                     flags_out,
   output logic [3:0]                     bank_select_register_out,
   output logic [7:0]                     pc_high_latch_out,
   output logic [7:0]                     pc_upper_latch_out,
   output logic                           high_priority_global_enable_out,
   output logic                           low_priority_global_enable_out,
   output logic                           flush_out,
   output logic                           busy_out,
   output logic                           sw_reset_out
);
   import crs_pkg::*;

   logic       rst_sync1_ff;
   logic       rst_sync2_ff;
   logic       rst_n;

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_sync1_ff <= 1'b0;
         rst_sync2_ff <= 1'b0;
      end
      else
      begin
         rst_sync1_ff <= 1'b1;
         rst_sync2_ff <= rst_sync1_ff;
      end
   end

   crs_stack_if stk ();

   crs_stack_mem u_stack (
      .clock_in (clock_in),
      .rst_n_in (rst_n),
      .stk      (stk)
   );

   function automatic logic is_relcall(input logic [15:0] w);
      return (w[15:12] == OP_RELCALL_TOP) && w[RELCALL_SEL_BIT];
   endfunction

   function automatic logic is_iret(input logic [15:0] w);
      return w[15:1] == OP_IRET_TOP;
   endfunction

   function automatic logic is_retlit(input logic [15:0] w);
      return w[15:8] == OP_RETLIT_TOP;
   endfunction

   crs_state_t          state_ff;
   crs_state_t          nxt_state;
   logic [PC_W-1:0]     pc_ff;
   logic [PC_W-1:0]     nxt_pc;
   logic                pc_load_ff;
   logic                nxt_pc_load;
   logic [7:0]          working_ff;
   logic [7:0]          nxt_working;
   logic [7:0]          flags_ff;
   logic [7:0]          nxt_flags;
   logic [3:0]          bank_ff;
   logic [3:0]          nxt_bank;
   logic [7:0]          pch_ff;
   logic [7:0]          nxt_pch;
   logic [7:0]          pcu_ff;
   logic                en_hi_ff;
   logic                nxt_en_hi;
   logic                en_lo_ff;
   logic                nxt_en_lo;
   logic                busy_ff;
   logic                nxt_busy;
   // a return is still owed its pop until it has happened once
   logic                lit_pending_ff;
   logic                nxt_lit_pending;
   logic                flush_ff;
   logic                nxt_flush;
   logic                swrst_ff;
   logic                nxt_swrst;
   logic                ret_kind_ff;
   logic                nxt_ret_kind;
   logic                shadow_ff;
   logic                nxt_shadow;
   logic [7:0]          lit_ff;
   logic [7:0]          nxt_lit;
   logic                push;
   logic                pop;
   logic [PC_W-1:0]     ofs2;

   // software reset pulse joins the external reset; sync copy keeps async entry
   assign rst_n = rst_sync2_ff && !swrst_ff;

   assign ofs2 = {{(PC_W-OFS_W-1){instr_in[OFS_W-1]}}, instr_in[OFS_W-1:0], 1'b0};

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_pc       = pc_ff;
      nxt_pc_load  = 1'b0;
      nxt_working  = working_ff;
      nxt_flags    = flags_ff;
      nxt_bank     = bank_ff;
      nxt_pch      = pc_high_latch_we_in ? pc_high_latch_wr_in : pch_ff;
      nxt_en_hi    = en_hi_ff;
      nxt_en_lo    = en_lo_ff;
      nxt_flush    = flush_ff;
      nxt_swrst    = 1'b0;
      nxt_ret_kind = ret_kind_ff;
      nxt_shadow   = shadow_ff;
      nxt_lit      = lit_ff;
      push         = 1'b0;
      pop          = 1'b0;
      case (state_ff)
         CRS_EXEC:
         begin
            if (instr_valid_in && q_phase_in == Q2)
            begin
               if (instr_in == OP_SWRESET)
                  nxt_swrst = 1'b1;
               else if (is_relcall(instr_in))
               begin
                  push        = 1'b1;
                  nxt_pc      = (pc_in + PC_STEP) + ofs2;
                  nxt_pc_load = 1'b1;
                  nxt_flush   = 1'b1;
                  nxt_state   = CRS_FLUSH;
               end
               else if (is_iret(instr_in) || is_retlit(instr_in))
               begin
                  nxt_ret_kind = is_iret(instr_in);
                  nxt_shadow   = instr_in[0];
                  nxt_lit      = instr_in[7:0];
                  nxt_flush    = 1'b1;
                  nxt_state    = CRS_FLUSH;
               end
            end
         end
         CRS_FLUSH:
         begin
            // pop at Q4 of first cycle
            if (flush_ff && q_phase_in == Q4 && !pc_load_ff && lit_pending_ff)
            begin
               pop         = 1'b1;
               nxt_pc      = stk.top_data;
               nxt_pc_load = 1'b1;
               if (ret_kind_ff)
               begin
                  if (irq_high_level_in)
                     nxt_en_hi = 1'b1;
                  else
                     nxt_en_lo = 1'b1;
                  if (shadow_ff)
                  begin
                     nxt_working = working_shadow_in;
                     nxt_flags   = flags_shadow_in;
                     nxt_bank    = bank_select_shadow_in;
                  end
               end
               else
                  nxt_working = lit_ff;
            end
            else if (q_phase_in == Q1 && !lit_pending_ff)
            begin
               nxt_flush = 1'b0;
               nxt_state = CRS_EXEC;
            end
         end
         default:
            nxt_state = CRS_EXEC;
      endcase
   end

   always_comb
   begin
      // busy registered so the port comes straight from a flop
      nxt_busy        = nxt_state == CRS_FLUSH;
      nxt_lit_pending = lit_pending_ff;
      if (state_ff == CRS_EXEC && nxt_state == CRS_FLUSH && !push)
         nxt_lit_pending = 1'b1;
      else if (pop)
         nxt_lit_pending = 1'b0;
   end

   assign stk.push      = push;
   assign stk.pop       = pop;
   assign stk.push_data = pc_in + PC_STEP;

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff       <= CRS_EXEC;
         pc_ff          <= PC_RST;
         pc_load_ff     <= 1'b0;
         working_ff     <= BYTE_RST;
         flags_ff       <= BYTE_RST;
         bank_ff        <= BANK_RST;
         pch_ff         <= BYTE_RST;
         pcu_ff         <= BYTE_RST;
         en_hi_ff       <= 1'b0;
         en_lo_ff       <= 1'b0;
         busy_ff        <= 1'b0;
         flush_ff       <= 1'b0;
         ret_kind_ff    <= 1'b0;
         shadow_ff      <= 1'b0;
         lit_ff         <= BYTE_RST;
         lit_pending_ff <= 1'b0;
      end
      else
      begin
         state_ff       <= nxt_state;
         pc_ff          <= nxt_pc;
         pc_load_ff     <= nxt_pc_load;
         working_ff     <= nxt_working;
         flags_ff       <= nxt_flags;
         bank_ff        <= nxt_bank;
         pch_ff         <= nxt_pch;
         pcu_ff         <= pcu_ff;
         en_hi_ff       <= nxt_en_hi;
         en_lo_ff       <= nxt_en_lo;
         busy_ff        <= nxt_busy;
         flush_ff       <= nxt_flush;
         ret_kind_ff    <= nxt_ret_kind;
         shadow_ff      <= nxt_shadow;
         lit_ff         <= nxt_lit;
         lit_pending_ff <= nxt_lit_pending;
      end
   end

   // reset request flop lives on the synchronised external reset only
   always_ff @(posedge clock_in or negedge rst_sync2_ff)
   begin
      if (!rst_sync2_ff)
         swrst_ff <= 1'b0;
      else
         swrst_ff <= nxt_swrst;
   end

   assign pc_out                          = pc_ff;
   assign pc_load_out                     = pc_load_ff;
   assign stack_top_value_out             = stk.top_data;
   assign working_out                     = working_ff;
   assign flags_out                       = flags_ff;
   assign bank_select_register_out        = bank_ff;
   assign pc_high_latch_out               = pch_ff;
   assign pc_upper_latch_out              = pcu_ff;
   assign high_priority_global_enable_out = en_hi_ff;
   assign low_priority_global_enable_out  = en_lo_ff;
   assign flush_out                       = flush_ff;
   assign busy_out                        = busy_ff;
   assign sw_reset_out                    = swrst_ff;
endmodule
`default_nettype wire

// [sim/crs_core_sva.sv]
// concurrent checks on the call and return block ports
`timescale 1ns/10ps
`default_nettype none
module crs_core_sva
   import crs_pkg::*;
(
   input wire logic            clock_in,
   input wire logic            nrst_in,
   input wire logic [1:0]      q_phase_in,
   input wire logic            instr_valid_in,
   input wire logic [15:0]     instr_in,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic            irq_high_level_in,
   input wire logic [7:0]      working_shadow_in,
   input wire logic [3:0]      bank_select_shadow_in,
   input wire logic            pc_high_latch_we_in,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic            pc_load_out,
   input wire logic [PC_W-1:0] stack_top_value_out,
   input wire logic [7:0]      working_out,
   input wire logic [7:0]      flags_out,
   input wire logic [3:0]      bank_select_register_out,
   input wire logic [7:0]      pc_high_latch_out,
   input wire logic [7:0]      pc_upper_latch_out,
   input wire logic            high_priority_global_enable_out,
   input wire logic            flush_out,
   input wire logic            busy_out,
   input wire logic            sw_reset_out
);
   logic            tk;
   logic            is_call;
   logic            is_ret;
   logic            is_lit;
   logic [15:0]     ins_ff;
   logic [15:0]     nxt_ins;
   logic [PC_W-1:0] pc_ff;
   logic [PC_W-1:0] nxt_pc;
   logic [PC_W-1:0] top_ff;
   logic [PC_W-1:0] nxt_top;
   assign tk = q_phase_in == Q2 && instr_valid_in && !busy_out;
   assign is_call = tk && instr_in[15:11] == {OP_RELCALL_TOP, 1'b1};
   assign is_ret = tk && instr_in[15:1] == OP_IRET_TOP;
   assign is_lit = tk && instr_in[15:8] == OP_RETLIT_TOP;
   // operands held from decode; Q2 recurring only every four clocks keeps them valid
   always_comb
   begin
      nxt_ins = tk ? instr_in : ins_ff;
      nxt_pc = tk ? pc_in : pc_ff;
      nxt_top = tk ? stack_top_value_out : top_ff;
   end
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ins_ff <= 16'h0000;
         pc_ff <= PC_RST;
         top_ff <= PC_RST;
      end
      else
      begin
         ins_ff <= nxt_ins;
         pc_ff <= nxt_pc;
         top_ff <= nxt_top;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   call_target_a : assert property (is_call |=> pc_load_out &&
      pc_out == pc_ff + PC_STEP + {{9{ins_ff[10]}}, ins_ff[10:0], 1'b0}) else $error("call target");
   call_push_a : assert property (is_call |->
      ##[1:4] stack_top_value_out == pc_ff + PC_STEP) else $error("call push");
   call_flush_a : assert property (is_call |=> flush_out) else $error("call flush");
   call_flags_a : assert property (is_call |=> $stable(flags_out)[*7]) else $error("flags");
   call_slot_a : assert property (is_call |-> ##[2:4] busy_out) else $error("call slot");
   ret_pc_a : assert property ((is_ret || is_lit) |->
      ##[1:3] pc_load_out && pc_out == top_ff) else $error("return pc");
   lit_work_a : assert property (is_lit |->
      ##[1:3] pc_load_out && working_out == ins_ff[7:0]) else $error("literal");
   iret_en_a : assert property (is_ret && irq_high_level_in |->
      ##[1:4] high_priority_global_enable_out) else $error("enable");
   shadow_a : assert property (is_ret && instr_in[0] |-> ##[1:4]
      working_out == working_shadow_in && bank_select_register_out == bank_select_shadow_in)
      else $error("shadow");
   latch_keep_a : assert property (pc_load_out && !$past(pc_high_latch_we_in) |->
      $stable(pc_high_latch_out) && $stable(pc_upper_latch_out)) else $error("latch");
   swr_pulse_a : assert property (tk && instr_in == OP_SWRESET |=>
      sw_reset_out ##1 !sw_reset_out) else $error("soft reset");
   cover property (is_call);
   cover property (is_ret && instr_in[0]);
   cover property (sw_reset_out);
endmodule
bind crs_core crs_core_sva i_crs_core_sva (.*);
`default_nettype wire

// [sim/call_return_stack_ops_tb.sv]
// self-checking bench for the call and return block
`timescale 1ns/10ps
`default_nettype none
module call_return_stack_ops_tb;
   import crs_pkg::*;
   logic            clock_in, nrst_in, instr_valid_in, irq_high_level_in;
   logic            pc_high_latch_we_in, pc_load_out, flush_out, busy_out, sw_reset_out;
   logic            high_priority_global_enable_out, low_priority_global_enable_out;
   logic [1:0]      q_phase_in;
   logic [15:0]     instr_in;
   logic [PC_W-1:0] pc_in, pc_out, stack_top_value_out;
   logic [7:0]      working_shadow_in, flags_shadow_in, pc_high_latch_wr_in;
   logic [7:0]      working_out, flags_out, pc_high_latch_out, pc_upper_latch_out;
   logic [3:0]      bank_select_shadow_in, bank_select_register_out;
   int              err_count;
   int              n_tests;
   crs_core i_crs_core (.*);
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) q_phase_in <= #1 q_phase_in + 2'h1;
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic hang();
      err_count++;
      print_verdict();
   endtask
   // instruction placed so that the Q2 edge takes it, never while busy
   task automatic issue(input logic [15:0] ins, input logic [PC_W-1:0] pc);
      int i;
      i = 0;
      do
      begin
         @(posedge clock_in);
         i++;
      end
      while ((q_phase_in !== 2'h0 || busy_out !== 1'b0) && i < 40);
      if (i >= 40) hang();
      #1;
      instr_valid_in = 1'b1;
      instr_in = ins;
      pc_in = pc;
      @(posedge clock_in);
      #1;
      instr_valid_in = 1'b0;
   endtask
   task automatic wait_for(input int which);
      int i;
      for (i = 0; i < 16 && (which ? sw_reset_out : pc_load_out) !== 1'b1; i++)
      begin
         @(posedge clock_in);
         #1;
      end
      if (i >= 16) hang();
   endtask
   task automatic settle();
      int i;
      for (i = 0; i < 16 && (busy_out !== 1'b0 || flush_out !== 1'b0); i++)
      begin
         @(posedge clock_in);
         #1;
      end
      if (i >= 16) hang();
   endtask
   task automatic t_call();
      issue(16'hD805, 21'h000100);
      wait_for(0);
      chk("call pc", pc_out, 21'h00010C);
      chk("call flush", 21'(flush_out), 21'h000001);
      settle();
      chk("call top", stack_top_value_out, 21'h000102);
      issue(16'hDC00, 21'h001000);
      wait_for(0);
      chk("back pc", pc_out, 21'h000802);
      settle();
   endtask
   task automatic t_ret();
      issue(16'h0CA5, 21'h000900);
      wait_for(0);
      chk("lit pc", pc_out, 21'h001002);
      chk("lit w", 21'(working_out), 21'h0000A5);
      settle();
      chk("latch", 21'(pc_high_latch_out), 21'h00007E);
      chk("popped top", stack_top_value_out, 21'h000102);
      issue(16'h0011, 21'h000A00);
      wait_for(0);
      chk("iret pc", pc_out, 21'h000102);
      settle();
      chk("shadow w", 21'(working_out), 21'h00003C);
      chk("shadow f", 21'(flags_out), 21'h00005A);
      chk("shadow b", 21'(bank_select_register_out), 21'h000009);
      chk("high en", 21'(high_priority_global_enable_out), 21'h000001);
      irq_high_level_in = 1'b0;
      issue(16'hD800, 21'h000200);
      wait_for(0);
      settle();
      chk("call flags", 21'(flags_out), 21'h00005A);
      issue(16'h0010, 21'h000300);
      wait_for(0);
      chk("iret0 pc", pc_out, 21'h000202);
      settle();
      chk("kept w", 21'(working_out), 21'h00003C);
      chk("low en", 21'(low_priority_global_enable_out), 21'h000001);
   endtask
   task automatic t_swr();
      issue(16'h00FF, 21'h000400);
      wait_for(1);
      settle();
      chk("rst w", 21'(working_out), 21'h000000);
      chk("rst top", stack_top_value_out, 21'h000000);
      chk("rst latch", 21'(pc_high_latch_out), 21'h000000);
      chk("rst en", 21'(low_priority_global_enable_out), 21'h000000);
   endtask
   initial
   begin
      err_count = 0;
      n_tests = 0;
      nrst_in = 1'b0;
      q_phase_in = 2'h0;
      instr_valid_in = 1'b0;
      instr_in = 16'h0000;
      pc_in = PC_RST;
      irq_high_level_in = 1'b1;
      working_shadow_in = 8'h3C;
      flags_shadow_in = 8'h5A;
      bank_select_shadow_in = 4'h9;
      pc_high_latch_we_in = 1'b0;
      pc_high_latch_wr_in = 8'h7E;
      repeat (16) @(posedge clock_in);
      #1 nrst_in = 1'b1;
      repeat (3) @(posedge clock_in);
      #1 pc_high_latch_we_in = 1'b1;
      @(posedge clock_in);
      #1 pc_high_latch_we_in = 1'b0;
      t_call();
      t_ret();
      t_swr();
      print_verdict();
   end
endmodule
`default_nettype wire
